// File: hdl/elc_defines.svh
// Purpose: Constants of the external line interrupt/event controller
// Assumes: 32-bit classic Wishbone register access
// Notes: Offsets are register word indices (address bits 4:2) within the bank
`ifndef ELC_DEFINES_SVH
`define ELC_DEFINES_SVH

`define ELC_LINES 19
`define ELC_PIN_LINES 16
`define ELC_LINE_LVD 16
`define ELC_LINE_RTC 17
`define ELC_LINE_USB 18
`define ELC_BASE_ADDR 32'h4001_0400
`define ELC_DEC_HI 31
`define ELC_DEC_LO 5
`define ELC_IDX_HI 4
`define ELC_IDX_LO 2
`define ELC_OFF_IRQ_UNMASK 3'h0
`define ELC_OFF_EVT_UNMASK 3'h1
`define ELC_OFF_RISE_EN 3'h2
`define ELC_OFF_FALL_EN 3'h3
`define ELC_OFF_SOFT_TRIG 3'h4
`define ELC_OFF_PENDING 3'h5
`define ELC_RESET_VAL 19'h0_0000
`define ELC_SEL_WORD 4'hF
`define ELC_RSVD_ZERO 13'h0000

`endif

// File: hdl/elc_pkg.sv
// Purpose: Types of the external line interrupt/event controller
// Assumes: Used with elc_defines.svh
// Notes: One-hot bus answer states
package elc_pkg;

   typedef enum logic [1:0] {
      ELC_ST_IDLE = 2'b01,
      ELC_ST_ACK = 2'b10
   } elc_bus_state_type;

   typedef logic [18:0] elc_line_vec_type;

endpackage

// File: hdl/elc_top.sv
// Purpose: External line interrupt and event controller, 19 lines
// Assumes: Pin line source selection is done outside; lines are async
// Notes: Registers on classic Wishbone, one-cycle registered ack
// Notes: Reads outside the six-word bank return zero with an ack
// Notes: A new trigger beats a pending clear in the same cycle
// Notes: Edges are ignored until the line history has filled
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "elc_defines.svh"

module elc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] pin_line_i,
   input wire logic low_voltage_detect_i,
   input wire logic rtc_alarm_i,
   input wire logic usb_wakeup_i,
   output logic [18:0] line_irq_o,
   output logic [18:0] line_event_o,
   output logic [18:0] wakeup_o
);

   // Helpers shared by the read mux and the write strobes
   // Register index of a bus address
   function automatic logic [2:0] f_index(input logic [31:0] adr);
      f_index = adr[`ELC_IDX_HI:`ELC_IDX_LO];
   endfunction

   // Address falls inside the six-word bank
   // Base is copied to a variable so that its upper bits can be sliced
   function automatic logic f_hit(input logic [31:0] adr);
      logic [2:0] idx;
      logic [31:0] base;
      idx = adr[`ELC_IDX_HI:`ELC_IDX_LO];
      base = `ELC_BASE_ADDR;
      f_hit = (adr[`ELC_DEC_HI:`ELC_DEC_LO] ==
               base[`ELC_DEC_HI:`ELC_DEC_LO]) &&
              (idx <= `ELC_OFF_PENDING);
   endfunction

   // Write strobe for one register
   function automatic logic f_wr(input logic wr, input logic [31:0] adr,
                                 input logic [2:0] off);
      f_wr = wr && f_hit(adr) && (f_index(adr) == off);
   endfunction

   // Register state
   elc_pkg::elc_bus_state_type bus_state_reg, bus_state_next;
   logic [31:0] dat_reg, dat_next;
   elc_pkg::elc_line_vec_type irq_unmask_reg, irq_unmask_next;
   elc_pkg::elc_line_vec_type evt_unmask_reg, evt_unmask_next;
   elc_pkg::elc_line_vec_type rise_en_reg, rise_en_next;
   elc_pkg::elc_line_vec_type fall_en_reg, fall_en_next;
   elc_pkg::elc_line_vec_type soft_reg, soft_next;
   elc_pkg::elc_line_vec_type pend_reg, pend_next;
   elc_pkg::elc_line_vec_type sync1_reg, sync1_next;
   elc_pkg::elc_line_vec_type sync2_reg, sync2_next;
   elc_pkg::elc_line_vec_type prev_reg, prev_next;
   elc_pkg::elc_line_vec_type irq_reg, irq_next;
   elc_pkg::elc_line_vec_type evt_reg, evt_next;
   elc_pkg::elc_line_vec_type wake_reg, wake_next;

   // Combinational line and bus signals
   elc_pkg::elc_line_vec_type raw_lines;
   elc_pkg::elc_line_vec_type rise_det;
   elc_pkg::elc_line_vec_type fall_det;
   elc_pkg::elc_line_vec_type soft_set;
   elc_pkg::elc_line_vec_type trig;
   logic req;
   logic wr_now;
   logic [18:0] wdat;

   // Fill flags that travel with the first samples after reset
   logic fill1_reg, fill1_next;
   logic fill2_reg, fill2_next;
   logic fill3_reg, fill3_next;
   elc_pkg::elc_line_vec_type hist_ok;

   // Port selection happens outside; bit n is always line n
   // Pin lines from the selected port pins
   // Internal sources on the upper three lines
   assign raw_lines = {usb_wakeup_i, rtc_alarm_i, low_voltage_detect_i,
                       pin_line_i};

   // Writes land on the ack edge, while the master still holds the request
   // Bus request and write moment (the ack edge)
   assign req = wb_cyc_i && wb_stb_i;
   assign wr_now = req && wb_we_i && (bus_state_reg == elc_pkg::ELC_ST_ACK)
                   && (wb_sel_i == `ELC_SEL_WORD);
   assign wdat = wb_dat_i[`ELC_LINES-1:0];

   // Every access is acked, mapped or not, so a stray one never hangs
   // Read data is captured at the taking edge and stands with ack
   // Bus answer state and read data
   always_comb begin
      bus_state_next = elc_pkg::ELC_ST_IDLE;
      dat_next = dat_reg;
      unique case (bus_state_reg)
         elc_pkg::ELC_ST_IDLE: begin
            if (req) begin
               bus_state_next = elc_pkg::ELC_ST_ACK;
               dat_next = 32'h0000_0000;
               if (!wb_we_i && f_hit(wb_adr_i)) begin
                  unique case (f_index(wb_adr_i))
                     `ELC_OFF_IRQ_UNMASK:
                        dat_next = {`ELC_RSVD_ZERO, irq_unmask_reg};
                     `ELC_OFF_EVT_UNMASK:
                        dat_next = {`ELC_RSVD_ZERO, evt_unmask_reg};
                     `ELC_OFF_RISE_EN:
                        dat_next = {`ELC_RSVD_ZERO, rise_en_reg};
                     `ELC_OFF_FALL_EN:
                        dat_next = {`ELC_RSVD_ZERO, fall_en_reg};
                     `ELC_OFF_SOFT_TRIG:
                        dat_next = {`ELC_RSVD_ZERO, soft_reg};
                     default:
                        dat_next = {`ELC_RSVD_ZERO, pend_reg};
                  endcase
               end
            end
         end
         elc_pkg::ELC_ST_ACK: begin
            bus_state_next = elc_pkg::ELC_ST_IDLE;
         end
         default: begin
            bus_state_next = elc_pkg::ELC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_reg <= elc_pkg::ELC_ST_IDLE;
         dat_reg <= 32'h0000_0000;
      end else begin
         bus_state_reg <= bus_state_next;
         dat_reg <= dat_next;
      end
   end

   // Ack comes from the state flop, one cycle after the request
   assign wb_ack_o = (bus_state_reg == elc_pkg::ELC_ST_ACK);
   assign wb_dat_o = dat_reg;

   // Configuration registers, one bit per line
   always_comb begin
      irq_unmask_next = irq_unmask_reg;
      evt_unmask_next = evt_unmask_reg;
      rise_en_next = rise_en_reg;
      fall_en_next = fall_en_reg;
      soft_next = soft_reg;
      // A partial-word write is acked but changes nothing
      // Interrupt unmask write
      if (f_wr(wr_now, wb_adr_i, `ELC_OFF_IRQ_UNMASK))
         irq_unmask_next = wdat;
      if (f_wr(wr_now, wb_adr_i, `ELC_OFF_EVT_UNMASK))
         evt_unmask_next = wdat;
      if (f_wr(wr_now, wb_adr_i, `ELC_OFF_RISE_EN))
         rise_en_next = wdat;
      if (f_wr(wr_now, wb_adr_i, `ELC_OFF_FALL_EN))
         fall_en_next = wdat;
      if (f_wr(wr_now, wb_adr_i, `ELC_OFF_SOFT_TRIG))
         soft_next = wdat;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_unmask_reg <= `ELC_RESET_VAL;
         evt_unmask_reg <= `ELC_RESET_VAL;
         rise_en_reg <= `ELC_RESET_VAL;
         fall_en_reg <= `ELC_RESET_VAL;
         soft_reg <= `ELC_RESET_VAL;
      end else begin
         irq_unmask_reg <= irq_unmask_next;
         evt_unmask_reg <= evt_unmask_next;
         rise_en_reg <= rise_en_next;
         fall_en_reg <= fall_en_next;
         soft_reg <= soft_next;
      end
   end

   // Rewriting a set bit does not fire; software writes 0 to re-arm
   // A 0-to-1 write of a trigger bit fires at once
   assign soft_set = soft_next & ~soft_reg;

   // History is trusted only once real samples fill it, so a line
   // already high when reset ends does not look like a rising edge
   assign hist_ok = {`ELC_LINES{fill3_reg}};

   // Edges from synchronised input versus previous sample
   assign rise_det = sync2_reg & ~prev_reg & hist_ok;
   assign fall_det = ~sync2_reg & prev_reg & hist_ok;

   // Trigger per line from its own enables
   // Pure bitwise logic, no line couples to another
   assign trig = (rise_det & rise_en_reg) | (fall_det & fall_en_reg) |
                 soft_set;

   // Line synchronisers and edge history
   // Two flops bring the async lines into the clock domain; the third
   // keeps the previous sample for the edge compare
   always_comb begin
      sync1_next = raw_lines;
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
      fill1_next = 1'h1;
      fill2_next = fill1_reg;
      fill3_next = fill2_reg;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg <= `ELC_RESET_VAL;
         sync2_reg <= `ELC_RESET_VAL;
         prev_reg <= `ELC_RESET_VAL;
         fill1_reg <= 1'h0;
         fill2_reg <= 1'h0;
         fill3_reg <= 1'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
         fill1_reg <= fill1_next;
         fill2_reg <= fill2_next;
         fill3_reg <= fill3_next;
      end
   end

   // Pending flags and outputs
   always_comb begin
      pend_next = pend_reg;
      // Write one clears a pending flag
      if (f_wr(wr_now, wb_adr_i, `ELC_OFF_PENDING))
         pend_next = pend_reg & ~wdat;
      // Only an unmasked interrupt sets pending, set wins
      pend_next = pend_next | (trig & irq_unmask_reg);
      // The next unmask value lets a mask write drop the request at once
      // Interrupt request held while pending and unmasked
      irq_next = pend_next & irq_unmask_next;
      // Event pulse lasts one clock per trigger
      evt_next = trig & evt_unmask_reg;
      wake_next = irq_next | evt_next;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= `ELC_RESET_VAL;
         irq_reg <= `ELC_RESET_VAL;
         evt_reg <= `ELC_RESET_VAL;
         wake_reg <= `ELC_RESET_VAL;
      end else begin
         pend_reg <= pend_next;
         irq_reg <= irq_next;
         evt_reg <= evt_next;
         wake_reg <= wake_next;
      end
   end

   // One request, event and wakeup bit per line
   assign line_irq_o = irq_reg;
   assign line_event_o = evt_reg;
   assign wakeup_o = wake_reg;

endmodule // elc_top

`default_nettype wire

// File: testbench/elc_top_assertions.sv
// Purpose: Port checker for the line controller
// Assumes: One clock, synchronous reset
// Notes: Shadows follow the unmask writes
`timescale 1ns/100ps
`default_nettype none
`include "elc_defines.svh"
module elc_top_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [18:0] line_irq_o,
   input wire logic [18:0] line_event_o,
   input wire logic [18:0] wakeup_o
);
   logic wr_ack;
   logic [18:0] irq_sh_reg, irq_sh_next, evt_sh_reg, evt_sh_next;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Full-word write acked in this cycle
   assign wr_ack = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i &
                   (wb_sel_i == 4'hF);
   // Shadows of the two unmask registers
   always_comb begin
      irq_sh_next = irq_sh_reg;
      evt_sh_next = evt_sh_reg;
      if (wr_ack && wb_adr_i == `ELC_BASE_ADDR)
         irq_sh_next = wb_dat_i[18:0];
      if (wr_ack && wb_adr_i == `ELC_BASE_ADDR + 32'h4)
         evt_sh_next = wb_dat_i[18:0];
   end
   always_ff @(posedge clk_i) begin
      irq_sh_reg <= rst_i ? 19'h0 : irq_sh_next;
      evt_sh_reg <= rst_i ? 19'h0 : evt_sh_next;
   end
   ack_answer_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   ack_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_quiet_a: assert property (
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   rsvd_zero_a: assert property (
      wb_ack_o |-> wb_dat_o[31:19] == 13'h0000) else $error("reserved set");
   unmapped_read_a: assert property (
      wb_ack_o && !wb_we_i && (wb_adr_i[31:5] != 27'h200_0820 ||
      wb_adr_i[4:2] > 3'h5) |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   wake_route_a: assert property (
      wakeup_o == (line_irq_o | line_event_o)) else $error("wakeup wrong");
   irq_mask_a: assert property (
      (line_irq_o & ~irq_sh_reg & ~$past(irq_sh_reg)) == 19'h0)
      else $error("masked irq raised");
   evt_mask_a: assert property (
      (line_event_o & ~evt_sh_reg & ~$past(evt_sh_reg)) == 19'h0)
      else $error("masked event raised");
   irq_hold_a: assert property (
      !wr_ack && !$past(wr_ack) |=>
      (line_irq_o & $past(line_irq_o)) == $past(line_irq_o))
      else $error("irq dropped unasked");
endmodule // elc_top_assertions
bind elc_top elc_top_assertions i_elc_top_assertions (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .line_irq_o, .line_event_o, .wakeup_o);
`default_nettype wire

// File: testbench/elc_core_model.sv
// Purpose: Core side that counts event pulses
// Assumes: Events are one-cycle pulses
// Notes: Counts wrap at 16
`timescale 1ns/100ps
`default_nettype none
module elc_core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [18:0] event_i
);
   logic [3:0] evt_cnt [19];
   always @(posedge clk_i) begin
      for (int i = 0; i < 19; i++) begin
         if (rst_i)
            evt_cnt[i] <= 4'h0;
         else if (event_i[i] === 1'b1)
            evt_cnt[i] <= evt_cnt[i] + 4'h1;
      end
   end
endmodule // elc_core_model
`default_nettype wire

// File: testbench/elc_top_test.sv
// Purpose: Self-checking bench of the line controller
// Assumes: Bus answers in one cycle
// Notes: Read answers are compared from a queue
`timescale 1ns/100ps
`default_nettype none
`include "elc_defines.svh"
module elc_top_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0] wb_sel_i = 4'h0;
   logic [15:0] pin_line_i = 16'h0, rnd = 16'hF297;
   logic low_voltage_detect_i = 1'b0, rtc_alarm_i = 1'b0;
   logic usb_wakeup_i = 1'b0, wb_ack_o;
   logic [18:0] line_irq_o, line_event_o, wakeup_o;
   logic [31:0] exp_q [$];
   int fail_count = 0;
   int num_checks = 0;
   elc_top i_elc_top (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .pin_line_i(pin_line_i),
      .low_voltage_detect_i(low_voltage_detect_i),
      .rtc_alarm_i(rtc_alarm_i),
      .usb_wakeup_i(usb_wakeup_i),
      .line_irq_o(line_irq_o),
      .line_event_o(line_event_o),
      .wakeup_o(wakeup_o)
   );
   elc_core_model i_elc_core_model (.clk_i(clk_i), .rst_i(rst_i),
      .event_i(line_event_o));
   always #10 clk_i = ~clk_i;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      // Every noted read must have been answered
      chk(32'(exp_q.size()), 32'h0);
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One classic single cycle, held until ack
   task automatic wb(input logic [4:0] o, input logic w,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_adr_i <= `ELC_BASE_ADDR + {27'h0, o};
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      // A missing ack counts as a mismatch; the run goes on to the report
      if (n >= 50)
         chk({31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] o, input logic [31:0] e);
      exp_q.push_back(e);
      wb(o, 1'b0, 32'h0, 4'hF);
   endtask
   // Compare each read answer with the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         // An answer with no note is itself a mismatch
         if (exp_q.size() == 0)
            chk(32'h0, 32'h1);
         else
            chk(wb_dat_o, exp_q.pop_front());
      end
   end
   task automatic lines(input logic v);
      pin_line_i <= {10'h0, {3{v}}, 3'h0};
      low_voltage_detect_i <= v;
      rtc_alarm_i <= v;
      usb_wakeup_i <= v;
      repeat (6) @(posedge clk_i);
   endtask
   initial begin
      logic [31:0] d;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int k = 0; k < 7; k++)
         rd(5'(k * 4), 32'h0);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         d = {rnd, lfsr(rnd)};
         wb(5'(k * 4), 1'b1, d, 4'hF);
         rd(5'(k * 4), {13'h0, d[18:0]});
      end
      wb(5'hC, 1'b1, 32'h0, 4'h3);
      rd(5'hC, {13'h0, d[18:0]});
      $display("Register test ended");
      wb(5'h8, 1'b1, 32'h7_0008, 4'hF);
      wb(5'hC, 1'b1, 32'h3_0020, 4'hF);
      wb(5'h0, 1'b1, 32'h5_0028, 4'hF);
      wb(5'h4, 1'b1, 32'h3_0028, 4'hF);
      lines(1'b1);
      rd(5'h14, 32'h5_0008);
      lines(1'b0);
      rd(5'h14, 32'h5_0028);
      chk({13'h0, line_irq_o}, 32'h5_0028);
      chk({8'h0, i_elc_core_model.evt_cnt[18],
         i_elc_core_model.evt_cnt[17], i_elc_core_model.evt_cnt[16],
         i_elc_core_model.evt_cnt[5], i_elc_core_model.evt_cnt[4],
         i_elc_core_model.evt_cnt[3]}, 32'h0002_2101);
      $display("Edge test ended");
      wb(5'h14, 1'b1, 32'h8, 4'hF);
      wb(5'h14, 1'b1, 32'h0, 4'hF);
      rd(5'h14, 32'h5_0020);
      wb(5'h0, 1'b1, 32'h80, 4'hF);
      wb(5'h4, 1'b1, 32'h80, 4'hF);
      chk({13'h0, line_irq_o}, 32'h0);
      wb(5'h10, 1'b1, 32'h80, 4'hF);
      rd(5'h10, 32'h80);
      rd(5'h14, 32'h5_00A0);
      chk({13'h0, line_irq_o}, 32'h80);
      chk({13'h0, wakeup_o}, 32'h80);
      chk({28'h0, i_elc_core_model.evt_cnt[7]}, 32'h1);
      $display("Software trigger test ended");
      // Let the watcher take the last read answer first
      repeat (2) @(posedge clk_i);
      test_done();
   end
endmodule // elc_top_test
`default_nettype wire
